// ### rtl/apfc_top.sv
// Purpose: dynamic averaging period and frequency counter
// Assumes: sig_in synchronous to clk; settings written while run is low
// Notes: timebase is clk; period in clk ticks, frequency in Hz
// Notes: one shared divider, so results come no faster than about one per 69 cycles
`timescale 1ns/1ps
`include "apfc_defines.svh"
module apfc_top
    import apfc_pkg::*;
#(
    parameter int CNT_W  = `APFC_CNT_W,
    parameter int DIV_W  = `APFC_DIV_W,
    parameter int CUT_W  = `APFC_CUT_W,
    parameter int CLK_HZ = `APFC_CLK_HZ
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Measured signal
    input  wire logic             sig_in,
    // Settings write
    input  wire logic             cfg_we,
    input  wire logic             cfg_filter_on,
    input  wire logic [CUT_W-1:0] cfg_filter_cutoff,
    input  wire logic [DIV_W-1:0] cfg_divisor,
    input  wire logic [CNT_W-1:0] cfg_meas_time,
    input  wire logic [CNT_W-1:0] cfg_max_period,
    // Acquisition control
    input  wire logic             run,
    // Settings readback
    output logic                  filter_on,
    output logic [CUT_W-1:0]      filter_cutoff,
    output logic [CNT_W-1:0]      filter_latency,
    // Results
    output logic                  res_valid,
    output logic                  res_no_meas,
    output logic [CNT_W-1:0]      res_period,
    output logic [CNT_W-1:0]      res_freq,
    output logic [DIV_W-1:0]      res_periods
);
    // Settings registers, private to this instance
    logic                  filt_reg;
    logic [CUT_W-1:0]      cut_reg;
    logic [DIV_W-1:0]      divisor_reg;
    logic [CNT_W-1:0]      mtime_reg;
    logic [CNT_W-1:0]      maxper_reg;
    logic [CNT_W-1:0]      lat_reg;
    // Measurement state
    apfc_state_t           state_reg;
    apfc_state_t           state_next;
    logic [CNT_W-1:0]      ticks_reg;
    logic [CNT_W-1:0]      since_edge_reg;
    logic [DIV_W-1:0]      nper_reg;
    logic [CNT_W-1:0]      ftick_reg;
    logic [CNT_W-1:0]      fper_reg;
    // Results
    logic                  valid_reg;
    logic                  nomeas_reg;
    logic [CNT_W-1:0]      period_reg;
    logic [CNT_W-1:0]      freq_reg;
    logic [DIV_W-1:0]      nres_reg;
    // Divider control
    logic                  div_start_reg;
    logic                  div_phase_reg;
    logic [CNT_W-1:0]      div_num_reg;
    logic [CNT_W-1:0]      div_den_reg;
    logic                  div_busy;
    logic                  div_done;
    logic [CNT_W-1:0]      div_quo;
    logic                  rise;

    apfc_edge u_edge (
        .clk    (clk),
        .arst_n (arst_n),
        .sig_in (sig_in),
        .rise   (rise)
    );

    // One divider for both quotients, period first and then frequency.
    // Cheaper than two dividers, at the cost of the fastest result rate.
    apfc_div #(.W(CNT_W)) u_div (
        .clk    (clk),
        .arst_n (arst_n),
        .start  (div_start_reg),
        .num    (div_num_reg),
        .den    (div_den_reg),
        .busy   (div_busy),
        .done   (div_done),
        .quo    (div_quo)
    );

    // Settings: only taken while idle so they never change mid-run
    wire cfg_take = cfg_we && (state_reg == APFC_IDLE);

    // Filter mode overrides the averaging limits
    wire             eff_filt    = filt_reg;
    wire [DIV_W-1:0] eff_div     = eff_filt ? {{(DIV_W-1){1'b0}}, 1'b1} : divisor_reg;
    wire [CNT_W-1:0] eff_mtime   = eff_filt ? '0 : mtime_reg;
    wire [CNT_W-1:0] eff_maxper  = eff_filt ? '0 : maxper_reg;

    // Limits: zero disables; both zero means one period
    wire div_hit   = (eff_div != '0) && (nper_reg + DIV_W'(1) >= eff_div);
    // Whole periods only: close once one more period would overrun the time.
    // The period just ended stands in for the next, so a drifting input can
    // be one period off in the count.
    wire [CNT_W:0] span_next = {1'b0, ticks_reg} + {1'b0, since_edge_reg} + (CNT_W+1)'(2);
    wire time_hit  = (eff_mtime != '0) && (span_next > {1'b0, eff_mtime});
    wire none_set  = (eff_div == '0) && (eff_mtime == '0);
    // Close at an edge: divisor reached, time used up, or one period minimum
    wire close_now = rise && (div_hit || time_hit || none_set);
    // Closing edge the divider can take; while it is busy the interval
    // restarts instead, so no result averages past the limits
    wire close_take = (state_reg == APFC_MEAS) && close_now && !div_busy;
    // Timeout only counts while waiting on edges, never during a divide
    wire watch     = (state_reg == APFC_ARM) || (state_reg == APFC_MEAS);
    wire timeout   = watch && (eff_maxper != '0) && (since_edge_reg + CNT_W'(1) >= eff_maxper);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            // Only here do settings land
            APFC_IDLE: begin
                if (run) begin
                    state_next = APFC_ARM;
                end
            end
            // First edge starts timing, so no partial period counts
            APFC_ARM: begin
                if (!run) begin
                    state_next = APFC_IDLE;
                end else if (rise) begin
                    state_next = APFC_MEAS;
                end
            end
            // Timing whole periods until a limit is met
            APFC_MEAS: begin
                if (!run) begin
                    state_next = APFC_IDLE;
                end else if (close_take) begin
                    state_next = APFC_DONE;
                end else if (timeout) begin
                    // Input lost: rearm so the gap never enters an average
                    state_next = APFC_ARM;
                end
            end
            // Both divisions run here; edges still accumulate
            APFC_DONE: begin
                if (div_done && div_phase_reg) begin
                    state_next = run ? APFC_MEAS : APFC_IDLE;
                end
            end
            default: state_next = APFC_IDLE;
        endcase
    end

    // Settings registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            filt_reg    <= `APFC_FILT_ON_RST;
            cut_reg     <= `APFC_CUT_RST;
            divisor_reg <= `APFC_DIV_RST;
            mtime_reg   <= `APFC_MTIME_RST;
            maxper_reg  <= `APFC_MAXPER_RST;
        end else if (cfg_take) begin
            filt_reg    <= cfg_filter_on;
            cut_reg     <= cfg_filter_cutoff;
            divisor_reg <= cfg_divisor;
            mtime_reg   <= cfg_meas_time;
            maxper_reg  <= cfg_max_period;
        end
    end

    // Latency of a 2^cutoff-tap averaging filter: half the window of periods
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lat_reg <= '0;
        end else begin
            lat_reg <= filt_reg ? CNT_W'(period_reg << cut_reg) >> 1 : '0;
        end
    end

    // Tick and period accumulation; measurement restarts at closing edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= APFC_IDLE;
            ticks_reg <= '0;
            nper_reg  <= '0;
        end else begin
            state_reg <= state_next;
            // Closing edge in MEAS or DONE: start afresh; while dividing the interval is dropped
            if ((state_reg == APFC_MEAS || state_reg == APFC_DONE) && close_now) begin
                ticks_reg <= '0;
                nper_reg  <= '0;
            end else if (state_reg == APFC_MEAS || state_reg == APFC_DONE) begin
                ticks_reg <= ticks_reg + CNT_W'(1);
                if (rise) begin
                    nper_reg <= nper_reg + DIV_W'(1);
                end
            end else begin
                // Idle or arming: nothing accumulates
                ticks_reg <= '0;
                nper_reg  <= '0;
            end
        end
    end

    // Cycles since the last rising edge, for timeout and whole-period fit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            since_edge_reg <= '0;
        end else if (rise || state_reg == APFC_IDLE || timeout) begin
            since_edge_reg <= '0;
        end else begin
            since_edge_reg <= since_edge_reg + CNT_W'(1);
        end
    end

    // Ticks of the interval closing now
    wire [CNT_W-1:0] span_ticks = ticks_reg + CNT_W'(1);
    // Filter mode: exponential smoothing of ticks, weight 2^-cutoff
    wire [CNT_W-1:0] fsum       = ftick_reg - (ftick_reg >> cut_reg) + (span_ticks >> cut_reg);
    // First filtered period seeds the smoother, so it starts settled
    wire [CNT_W-1:0] filt_ticks = (ftick_reg == '0) ? span_ticks : fsum;
    // Division operands frozen at the closing edge
    wire [CNT_W-1:0] snap_num   = eff_filt ? filt_ticks : span_ticks;
    wire [CNT_W-1:0] snap_den   = eff_filt ? CNT_W'(1) : CNT_W'(nper_reg) + CNT_W'(1);
    wire [DIV_W-1:0] snap_n     = eff_filt ? DIV_W'(1) : nper_reg + DIV_W'(1);

    // Frozen snapshot for the two divisions, then result update
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_start_reg <= 1'b0;
            div_phase_reg <= 1'b0;
            div_num_reg   <= '0;
            div_den_reg   <= '0;
            ftick_reg     <= '0;
            fper_reg      <= '0;
            valid_reg     <= 1'b0;
            nomeas_reg    <= 1'b0;
            period_reg    <= '0;
            freq_reg      <= '0;
            nres_reg      <= '0;
        end else begin
            div_start_reg <= 1'b0;
            valid_reg     <= 1'b0;
            if (close_take) begin
                // Smoother state belongs to filter mode only
                ftick_reg     <= eff_filt ? filt_ticks : '0;
                div_num_reg   <= snap_num;
                div_den_reg   <= snap_den;
                nres_reg      <= snap_n;
                div_start_reg <= 1'b1;
                div_phase_reg <= 1'b0;
            end else if (div_done && !div_phase_reg) begin
                // Period known; now the frequency from it
                fper_reg      <= div_quo;
                div_num_reg   <= CNT_W'(CLK_HZ);
                div_den_reg   <= (div_quo == '0) ? CNT_W'(1) : div_quo;
                div_start_reg <= 1'b1;
                div_phase_reg <= 1'b1;
            end else if (div_done && div_phase_reg) begin
                // Both quotients in: publish
                period_reg    <= fper_reg;
                freq_reg      <= div_quo;
                nomeas_reg    <= 1'b0;
                valid_reg     <= 1'b1;
                div_phase_reg <= 1'b0;
            end else if (timeout && (state_reg == APFC_ARM || state_reg == APFC_MEAS)) begin
                freq_reg      <= '0;
                period_reg    <= '0;
                nres_reg      <= '0;
                nomeas_reg    <= 1'b1;
                valid_reg     <= 1'b1;
            end else if (state_reg == APFC_IDLE) begin
                // Each new run starts its smoother afresh
                ftick_reg     <= '0;
            end
        end
    end

    // Every output is a register
    assign filter_on      = filt_reg;
    assign filter_cutoff  = cut_reg;
    assign filter_latency = lat_reg;
    assign res_valid      = valid_reg;
    assign res_no_meas    = nomeas_reg;
    assign res_period     = period_reg;
    assign res_freq       = freq_reg;
    assign res_periods    = nres_reg;
endmodule // apfc_top

// ### inc/apfc_defines.svh
// Purpose: constants for the averaging period/frequency counter
// Assumes: 40 MHz clock, count widths set by module parameters
// Notes: times given directly as clk cycle counts, none derived
`ifndef APFC_DEFINES_SVH
`define APFC_DEFINES_SVH

`define APFC_CLK_HZ          40000000
`define APFC_CNT_W           32
`define APFC_DIV_W           16
`define APFC_CUT_W           4
`define APFC_FILT_ON_RST     1'b1
`define APFC_DIV_RST         16'h0001
`define APFC_MTIME_RST       32'h0000_0000
`define APFC_MAXPER_RST      32'h0262_5A00
`define APFC_CUT_RST         4'h4

`endif

// ### inc/apfc_pkg.sv
// Purpose: types for the averaging period/frequency counter
// Assumes: nothing beyond the defines header
// Notes: one-hot state codes
package apfc_pkg;
    typedef enum logic [3:0] {
        APFC_IDLE = 4'h1,
        APFC_ARM  = 4'h2,
        APFC_MEAS = 4'h4,
        APFC_DONE = 4'h8
    } apfc_state_t;
endpackage

// ### rtl/apfc_edge.sv
// Purpose: rising edge detect of the measured input
// Assumes: input already synchronous to clk
// Notes: one-cycle pulse per rising edge
`timescale 1ns/1ps
module apfc_edge (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Signal
    input  wire logic sig_in,
    output logic      rise
);
    logic prev_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sig_in;
        end
    end

    assign rise = sig_in & ~prev_reg;
endmodule // apfc_edge

// ### rtl/apfc_div.sv
// Purpose: sequential unsigned divider, one quotient bit per cycle
// Assumes: divisor nonzero when started
// Notes: done is a one-cycle pulse, W+1 cycles after start
`timescale 1ns/1ps
module apfc_div #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Request
    input  wire logic         start,
    input  wire logic [W-1:0] num,
    input  wire logic [W-1:0] den,
    // Answer
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quo
);
    logic [W-1:0]   rem_reg;
    logic [W-1:0]   q_reg;
    logic [W-1:0]   d_reg;
    logic [5:0]     cnt_reg;
    logic           busy_reg;
    logic           done_reg;
    logic [W:0]     trial;
    logic [W:0]     shifted;

    assign shifted = {rem_reg, q_reg[W-1]};
    assign trial   = shifted - {1'b0, d_reg};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rem_reg  <= '0;
            q_reg    <= '0;
            d_reg    <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start && !busy_reg) begin
                rem_reg  <= '0;
                q_reg    <= num;
                d_reg    <= den;
                cnt_reg  <= 6'(W);
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (!trial[W]) begin
                    rem_reg <= trial[W-1:0];
                    q_reg   <= {q_reg[W-2:0], 1'b1};
                end else begin
                    rem_reg <= shifted[W-1:0];
                    q_reg   <= {q_reg[W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 6'h01;
                if (cnt_reg == 6'h01) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign quo  = q_reg;
endmodule // apfc_div

// ### verif/apfc_checker.sv
// Purpose: port-level assertions for apfc_top
// Assumes: settings change only while run is low
// Notes: bound from the tb file
`timescale 1ns/1ps
module apfc_checker #(
    parameter int CNT_W = 32,
    parameter int DIV_W = 16,
    parameter int CUT_W = 4
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             arst_n,
    // Inputs
    input wire logic             sig_in,
    input wire logic             cfg_we,
    input wire logic [DIV_W-1:0] cfg_divisor,
    input wire logic [CNT_W-1:0] cfg_max_period,
    input wire logic             run,
    // Outputs
    input wire logic             filter_on,
    input wire logic [CUT_W-1:0] filter_cutoff,
    input wire logic [CNT_W-1:0] filter_latency,
    input wire logic             res_valid,
    input wire logic             res_no_meas,
    input wire logic [CNT_W-1:0] res_period,
    input wire logic [CNT_W-1:0] res_freq,
    input wire logic [DIV_W-1:0] res_periods
);
    logic [DIV_W-1:0] div_reg;
    logic [CNT_W-1:0] maxp_reg;
    logic [CNT_W-1:0] gap_reg;
    logic             sig_d_reg;

    // Shadow of the settings plus cycles since the last input rise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg   <= DIV_W'(16'h0001);
            maxp_reg  <= CNT_W'(32'h0262_5A00);
            gap_reg   <= '0;
            sig_d_reg <= 1'b0;
        end else begin
            if (cfg_we && !run) begin
                div_reg  <= cfg_divisor;
                maxp_reg <= cfg_max_period;
            end
            gap_reg   <= (!run || (sig_in && !sig_d_reg)) ? '0 : gap_reg + CNT_W'(1);
            sig_d_reg <= sig_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_good;
        res_valid && !res_no_meas;
    endsequence
    sequence s_timeout;
        res_valid && res_no_meas;
    endsequence

    chk_one_pulse: assert property (res_valid |=> !res_valid)
        else $error("result strobe longer than one cycle");
    chk_period_set: assert property (s_good |-> res_periods != 0 && res_period != 0)
        else $error("result without periods or ticks");
    chk_div_limit: assert property (s_good ##0 (div_reg != 0) |-> res_periods <= div_reg)
        else $error("more periods averaged than divisor");
    chk_zero_freq: assert property (s_timeout |-> res_freq == 0)
        else $error("timeout result with nonzero frequency");
    chk_timeout_wait: assert property (s_timeout ##0 !filter_on |-> gap_reg + CNT_W'(2) >= maxp_reg)
        else $error("timeout reported too early");
    chk_filter_no_to: assert property (res_valid && filter_on |-> !res_no_meas)
        else $error("timeout while filtering");
    chk_reset_vals: assert property (!$past(arst_n) |-> filter_on && filter_cutoff == CUT_W'(4'h4))
        else $error("filter settings wrong after reset");
    chk_cfg_frozen: assert property (run && $past(run) |-> $stable(filter_on) && $stable(filter_cutoff))
        else $error("settings changed during acquisition");
    chk_latency_off: assert property ((!filter_on)[*3] |-> filter_latency == 0)
        else $error("latency nonzero with filter off");
endmodule // apfc_checker

// ### verif/apfc_sig_model.sv
// Purpose: measured input source with programmable period
// Assumes: per of 2 or more clk ticks
// Notes: held low while disabled
`timescale 1ns/1ps
module apfc_sig_model (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Control
    input wire logic        en,
    input wire logic [15:0] per,
    // Signal
    output logic            sig
);
    logic [15:0] cnt_reg;

    // Low when idle so no stray edge reaches the counter
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 16'h0000;
            sig     <= 1'b0;
        end else if (!en) begin
            cnt_reg <= 16'h0000;
            sig     <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg + 16'h0001 >= per) ? 16'h0000 : cnt_reg + 16'h0001;
            sig     <= (cnt_reg < (per >> 1));
        end
    end
endmodule // apfc_sig_model

// ### verif/tb.sv
// Purpose: self-checking bench for apfc_top
// Assumes: 40 MHz clock, model drives sig_in
// Notes: short max periods keep the run brief
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        arst_n;
    logic        sig_in;
    logic        cfg_we;
    logic        cfg_filter_on;
    logic [3:0]  cfg_filter_cutoff;
    logic [15:0] cfg_divisor;
    logic [31:0] cfg_meas_time;
    logic [31:0] cfg_max_period;
    logic        run;
    logic        en;
    logic [15:0] per;
    logic        filter_on;
    logic [3:0]  filter_cutoff;
    logic [31:0] filter_latency;
    logic        res_valid;
    logic        res_no_meas;
    logic [31:0] res_period;
    logic [31:0] res_freq;
    logic [15:0] res_periods;
    int          failures;
    int          cmp_count;
    int          cycles;

    apfc_top dut (.clk, .arst_n, .sig_in, .cfg_we, .cfg_filter_on, .cfg_filter_cutoff, .cfg_divisor,
                  .cfg_meas_time, .cfg_max_period, .run, .filter_on, .filter_cutoff, .filter_latency,
                  .res_valid, .res_no_meas, .res_period, .res_freq, .res_periods);
    apfc_sig_model src (.clk, .arst_n, .en, .per, .sig(sig_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Settings only land while idle; a divide in flight needs ~70 cycles to drain
    task automatic setup(input logic fo, input logic [3:0] k, input logic [15:0] d,
                         input logic [31:0] mt, input logic [31:0] mp, input logic [15:0] p);
        @(posedge clk);
        run               <= 1'b0;
        en                <= 1'b0;
        repeat (80) @(posedge clk);
        cfg_we            <= 1'b1;
        cfg_filter_on     <= fo;
        cfg_filter_cutoff <= k;
        cfg_divisor       <= d;
        cfg_meas_time     <= mt;
        cfg_max_period    <= mp;
        @(posedge clk);
        cfg_we            <= 1'b0;
        per               <= p;
        en                <= 1'b1;
        run               <= 1'b1;
    endtask

    task automatic wait_res();
        int n;
        n = 0;
        @(negedge clk);
        while (res_valid !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) check(32'h0, 32'h1);
    endtask

    // First result may follow a partial arm, so the second is judged
    task automatic measure(input logic [15:0] d, input logic [31:0] mt, input logic [15:0] p,
                           input logic [15:0] n);
        setup(1'b0, 4'h4, d, mt, 32'h0000_1000, p);
        wait_res();
        wait_res();
        check(res_periods, n);
        check(res_period, 32'(p));
        check(res_freq, 32'h0262_5A00 / 32'(p));
        check(res_no_meas, 1'b0);
        $display("measure done div %0d time %0d period %0d", d, mt, p);
    endtask

    task automatic t_timeout();
        int t;
        t = 0;
        setup(1'b0, 4'h4, 16'h0001, 32'h0, 32'h0000_00C8, 16'h0014);
        wait_res();
        @(posedge clk);
        en <= 1'b0;
        while (!(res_valid === 1'b1 && res_no_meas === 1'b1) && t < 1000) begin
            @(negedge clk);
            t++;
        end
        check(t >= 178 && t <= 270, 1'b1);
        check(res_freq, 32'h0);
        check(res_no_meas, 1'b1);
        $display("timeout test done");
    endtask

    // Max period far below the input period must not trip in filter mode
    task automatic t_filter();
        setup(1'b1, 4'h2, 16'h0001, 32'h0, 32'h0000_0032, 16'h0064);
        repeat (6) wait_res();
        @(posedge clk);
        cfg_we        <= 1'b1;
        cfg_filter_on <= 1'b0;
        repeat (2) @(posedge clk);
        cfg_we        <= 1'b0;
        @(negedge clk);
        check(filter_on, 1'b1);
        check(filter_cutoff, 4'h2);
        check(res_no_meas, 1'b0);
        check(filter_latency, 32'h0000_00C8);
        check(res_period, 32'h0000_0064);
        $display("filter test done");
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles > 30000) begin
                failures++;
                results();
            end
        end
    end

    initial begin
        failures          = 0;
        cmp_count         = 0;
        arst_n            = 1'b0;
        cfg_we            = 1'b0;
        cfg_filter_on     = 1'b0;
        cfg_filter_cutoff = 4'h0;
        cfg_divisor       = 16'h0000;
        cfg_meas_time     = 32'h0;
        cfg_max_period    = 32'h0;
        run               = 1'b0;
        en                = 1'b0;
        per               = 16'h0014;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check(filter_on, 1'b1);
        check(filter_cutoff, 4'h4);
        $display("reset test done");
        measure(16'h0004, 32'h0000_03E8, 16'h0014, 16'h0004);
        measure(16'h000A, 32'h0000_0064, 16'h001E, 16'h0003);
        measure(16'h000A, 32'h0000_0032, 16'h0050, 16'h0001);
        measure(16'h0000, 32'h0000_0064, 16'h001E, 16'h0003);
        measure(16'h0000, 32'h0000_0000, 16'h0014, 16'h0001);
        t_timeout();
        t_filter();
        results();
    end
endmodule // tb

bind apfc_top apfc_checker #(.CNT_W(CNT_W), .DIV_W(DIV_W), .CUT_W(CUT_W)) chk (
    .clk, .arst_n, .sig_in, .cfg_we, .cfg_divisor, .cfg_max_period, .run, .filter_on, .filter_cutoff,
    .filter_latency, .res_valid, .res_no_meas, .res_period, .res_freq, .res_periods);
